/* File: include/lpms_defines.svh */
`ifndef LPMS_DEFINES_SVH
`define LPMS_DEFINES_SVH

`define LPMS_AW 12
`define LPMS_PD_W 16
`define LPMS_NWAKE 40

// register byte offsets
`define LPMS_OFS_PCON 12'h000
`define LPMS_OFS_GP0 12'h004
`define LPMS_OFS_RUNCFG 12'h020
`define LPMS_OFS_SLPCFG 12'h024
`define LPMS_OFS_WAKCFG 12'h028
`define LPMS_OFS_DSCTL 12'h02C
`define LPMS_OFS_POL_LO 12'h030
`define LPMS_OFS_POL_HI 12'h034
`define LPMS_OFS_EN_LO 12'h038
`define LPMS_OFS_EN_HI 12'h03C
`define LPMS_OFS_CLR_LO 12'h040
`define LPMS_OFS_CLR_HI 12'h044
`define LPMS_OFS_PEND_LO 12'h048
`define LPMS_OFS_PEND_HI 12'h04C
`define LPMS_OFS_STAT 12'h050

// field positions
`define LPMS_PCON_DPD_BIT 1
`define LPMS_DSCTL_DEEP_BIT 0
`define LPMS_PD_RC_BIT 0

// reset values
`define LPMS_RUNCFG_RST 16'h0000
`define LPMS_SLPCFG_RST 16'h0000
`define LPMS_WAKCFG_RST 16'h0000

// timing
`define LPMS_CLK_MHZ 20
`define LPMS_ENTRY_DELAY_NS 30
`define LPMS_ENTRY_DELAY_CYC \
  (((`LPMS_ENTRY_DELAY_NS * `LPMS_CLK_MHZ) + 999) / 1000)

`endif

/* File: include/lpms_pkg.sv */
package lpms_pkg;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_HOLD,
    ST_ENTER,
    ST_RC_WAIT,
    ST_DELAY,
    ST_DEEP,
    ST_DPD
  } lpms_fsm_t;

  typedef struct packed {
    lpms_fsm_t fsm;
    logic pcon_dpd;
    logic deep_sel;
    logic [3:0][31:0] gp;
    logic [15:0] run_cfg;
    logic [15:0] sleep_cfg;
    logic [15:0] wake_cfg;
    logic [39:0] pol;
    logic [39:0] en;
    logic [39:0] pend;
    logic [39:0] pin_prev;
    logic [3:0] dcnt;
    logic [31:0] prdata;
  } lpms_state_t;

endpackage

/* File: rtl/lpms_sequencer.sv */
// Operation
// - wait-for-interrupt with Sleep selected stops the core clock
// - Sleep ends by itself when any interrupt reaches the core
// - peripherals run in Sleep; their interrupts wake the core
// - resuming Sleep only turns the core clock back on
// - Deep-sleep is Sleep plus power-down of selected analog blocks
// - Deep power-down keeps only wake pin logic and four retention words
// - after Deep-sleep wake, analog power follows wake configuration
// - Deep-sleep entry waits for the core hold acknowledge
// - while hold pends, the core may abandon entry
// - core withdrawing its hold also withdraws the Deep-sleep request
// - start-logic wakes are ignored during Deep-sleep entry
// - on request: core off, sleep config into run config, blocks off
// - fixed 30 ns delay after power-down, then wakes are accepted
// - with RC oscillator selected off, wait its ack before the delay
// - RC oscillator stops glitch-free, then acknowledges
// - forty port inputs feed start logic; its interrupt ends Deep-sleep
// - start logic has per-input programmable edge polarity
// - wake input n drives interrupt controller line n, 0 to 39
// - start logic latches edges; software clears pending before use
// - start logic also gives interrupts in normal run mode
// - wake configuration is copied into run configuration on exit
// - deep power-down select bit 1 picks Deep power-down over Sleep
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "lpms_defines.svh"
module lpms_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_for_interrupt_instr,
  input wire logic core_irq_pending,
  input wire logic core_hold_ack,
  output logic sleep_hold_req,
  output logic core_clk_en,
  output logic core_pwr_en,
  output logic deep_sleep_req,
  output logic in_deep_sleep,
  input wire logic internal_rc_osc_off_ack,
  output logic [15:0] run_power_config,
  input wire logic [39:0] port_pin,
  output logic [39:0] wake_irq,
  input wire logic deep_powerdown_wake_pin,
  output logic deep_powerdown_active
);

  lpms_pkg::lpms_state_t s_q;
  lpms_pkg::lpms_state_t s_d;

  logic acc;
  logic wr;
  logic [39:0] rise;
  logic [39:0] fall;
  logic [39:0] edge_hit;
  logic [39:0] clr;
  logic wake;
  logic [31:0] rdata;

  // address decode, used by write path and error answer
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a <= `LPMS_OFS_STAT) && (a[1:0] == 2'h0) &&
      !((a > (`LPMS_OFS_GP0 + 12'h00C)) && (a < `LPMS_OFS_RUNCFG));
  endfunction

  // 40-bit field split over a low and a high word
  function automatic logic [39:0] upd40(
    input logic [39:0] old,
    input logic [31:0] d,
    input logic hi
  );
    upd40 = hi ? {d[7:0], old[31:0]} : {old[39:32], d};
  endfunction

  // retention word index decode, shared by write and read paths
  function automatic logic gp_hit(input logic [11:0] a, input int i);
    gp_hit = (a == (`LPMS_OFS_GP0 + 12'(4 * i)));
  endfunction

  assign acc = psel & penable;
  // writes to unmapped or misaligned words are dropped
  assign wr = acc & pwrite & addr_ok(paddr);
  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  // error answer only in the access phase, never in setup
  assign pslverr = acc & ~addr_ok(paddr);
  assign prdata = s_q.prdata;

  always_comb
  begin
    // defaults hold every field; branches below override
    s_d = s_q;
    clr = 40'h00_0000_0000;
    rdata = 32'h0000_0000;

    // pins treated as synchronous; edges found against last sample
    rise = port_pin & ~s_q.pin_prev;
    fall = ~port_pin & s_q.pin_prev;
    s_d.pin_prev = port_pin;
    // enables are zero out of reset, so no false wake at start
    // an edge on a disabled input is dropped, not held
    // edge polarity
    edge_hit = s_q.en & ((s_q.pol & rise) | (~s_q.pol & fall));

    if (wr)
    begin
      case (paddr)
        `LPMS_OFS_PCON:
          s_d.pcon_dpd = pwdata[`LPMS_PCON_DPD_BIT];
        `LPMS_OFS_RUNCFG:
          // fsm owns the run config outside run state
          if (s_q.fsm == lpms_pkg::ST_RUN)
          begin
            s_d.run_cfg = pwdata[15:0];
          end
        `LPMS_OFS_SLPCFG:
          s_d.sleep_cfg = pwdata[15:0];
        `LPMS_OFS_WAKCFG:
          s_d.wake_cfg = pwdata[15:0];
        `LPMS_OFS_DSCTL:
          s_d.deep_sel = pwdata[`LPMS_DSCTL_DEEP_BIT];
        `LPMS_OFS_POL_LO,
        `LPMS_OFS_POL_HI:
          s_d.pol = upd40(s_q.pol, pwdata, paddr[2]);
        `LPMS_OFS_EN_LO,
        `LPMS_OFS_EN_HI:
          s_d.en = upd40(s_q.en, pwdata, paddr[2]);
        `LPMS_OFS_CLR_LO:
          clr = {8'h00, pwdata};
        `LPMS_OFS_CLR_HI:
          clr = {pwdata[7:0], 32'h0000_0000};
        default:
          for (int i = 0; i < 4; i++)
          begin
            if (gp_hit(paddr, i))
            begin
              s_d.gp[i] = pwdata;
            end
          end
      endcase
    end

    // edges latched; a new edge beats a same-cycle clear
    s_d.pend = (s_q.pend & ~clr) | edge_hit;
    // any enabled pending input is a wake
    wake = |(s_q.pend & s_q.en);

    case (s_q.fsm)
      lpms_pkg::ST_RUN:
        if (wait_for_interrupt_instr)
        begin
          if (s_q.pcon_dpd)
          begin
            s_d.fsm = lpms_pkg::ST_DPD;
          end
          else if (s_q.deep_sel)
          begin
            s_d.fsm = lpms_pkg::ST_HOLD;
          end
          else
          begin
            s_d.fsm = lpms_pkg::ST_SLEEP;
          end
        end
      lpms_pkg::ST_SLEEP:
        // plain sleep leaves analog power untouched
        // any interrupt resumes
        if (core_irq_pending)
        begin
          s_d.fsm = lpms_pkg::ST_RUN;
        end
      lpms_pkg::ST_HOLD:
        if (core_irq_pending)
        begin
          s_d.fsm = lpms_pkg::ST_RUN;
        end
        else if (core_hold_ack)
        begin
          s_d.fsm = lpms_pkg::ST_ENTER;
        end
      lpms_pkg::ST_ENTER:
        if (!core_hold_ack)
        begin
          s_d.fsm = lpms_pkg::ST_RUN;
        end
        else
        begin
          s_d.run_cfg = s_q.sleep_cfg;
          // delay rounded up to whole clock cycles
          s_d.dcnt = 4'(`LPMS_ENTRY_DELAY_CYC - 1);
          if (s_q.sleep_cfg[`LPMS_PD_RC_BIT])
          begin
            s_d.fsm = lpms_pkg::ST_RC_WAIT;
          end
          else
          begin
            s_d.fsm = lpms_pkg::ST_DELAY;
          end
        end
      lpms_pkg::ST_RC_WAIT:
        // a late oscillator ack holds entry here, no timeout
        // hold withdrawn
        if (!core_hold_ack)
        begin
          s_d.run_cfg = s_q.wake_cfg;
          s_d.fsm = lpms_pkg::ST_RUN;
        end
        else if (internal_rc_osc_off_ack)
        begin
          s_d.fsm = lpms_pkg::ST_DELAY;
        end
      lpms_pkg::ST_DELAY:
        // wakes ignored; pending stays latched for later
        if (!core_hold_ack)
        begin
          s_d.run_cfg = s_q.wake_cfg;
          s_d.fsm = lpms_pkg::ST_RUN;
        end
        else if (s_q.dcnt == 4'h0)
        begin
          s_d.fsm = lpms_pkg::ST_DEEP;
        end
        else
        begin
          s_d.dcnt = s_q.dcnt - 4'h1;
        end
      lpms_pkg::ST_DEEP:
        // start logic or withdrawn hold ends Deep-sleep
        if (wake || !core_hold_ack)
        begin
          s_d.run_cfg = s_q.wake_cfg;
          s_d.fsm = lpms_pkg::ST_RUN;
        end
      lpms_pkg::ST_DPD:
        // select bit stays set; software clears it after waking
        // only the wake pin brings the chip back
        if (deep_powerdown_wake_pin)
        begin
          s_d.fsm = lpms_pkg::ST_RUN;
        end
      default:
        s_d.fsm = lpms_pkg::ST_RUN;
    endcase

    case (paddr)
      `LPMS_OFS_PCON:
        rdata = {30'h0000_0000, s_q.pcon_dpd, 1'b0};
      `LPMS_OFS_RUNCFG:
        rdata = {16'h0000, s_q.run_cfg};
      `LPMS_OFS_SLPCFG:
        rdata = {16'h0000, s_q.sleep_cfg};
      `LPMS_OFS_WAKCFG:
        rdata = {16'h0000, s_q.wake_cfg};
      `LPMS_OFS_DSCTL:
        rdata = {31'h0000_0000, s_q.deep_sel};
      `LPMS_OFS_POL_LO:
        rdata = s_q.pol[31:0];
      `LPMS_OFS_POL_HI:
        rdata = {24'h00_0000, s_q.pol[39:32]};
      `LPMS_OFS_EN_LO:
        rdata = s_q.en[31:0];
      `LPMS_OFS_EN_HI:
        rdata = {24'h00_0000, s_q.en[39:32]};
      `LPMS_OFS_PEND_LO:
        rdata = s_q.pend[31:0];
      `LPMS_OFS_PEND_HI:
        rdata = {24'h00_0000, s_q.pend[39:32]};
      `LPMS_OFS_STAT:
        rdata = {29'h0000_0000, s_q.fsm};
      // clear words are write-only and read back zero
      default:
        for (int i = 0; i < 4; i++)
        begin
          if (gp_hit(paddr, i))
          begin
            rdata = s_q.gp[i];
          end
        end
    endcase
    if (psel && !penable)
    begin
      s_d.prdata = rdata;
    end
  end

  // a true reset clears retention words too; only DPD keeps them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.fsm <= lpms_pkg::ST_RUN;
      s_q.run_cfg <= `LPMS_RUNCFG_RST;
      s_q.sleep_cfg <= `LPMS_SLPCFG_RST;
      s_q.wake_cfg <= `LPMS_WAKCFG_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // core clock runs only in run state
  assign core_clk_en = (s_q.fsm == lpms_pkg::ST_RUN);
  // core powered down from the cycle after entry until wake
  assign core_pwr_en = !(s_q.fsm inside {lpms_pkg::ST_RC_WAIT,
    lpms_pkg::ST_DELAY, lpms_pkg::ST_DEEP, lpms_pkg::ST_DPD});
  assign sleep_hold_req = (s_q.fsm == lpms_pkg::ST_HOLD);
  // request held through entry so power lines do not glitch
  assign deep_sleep_req = s_q.fsm inside {lpms_pkg::ST_ENTER,
    lpms_pkg::ST_RC_WAIT, lpms_pkg::ST_DELAY, lpms_pkg::ST_DEEP};
  assign in_deep_sleep = (s_q.fsm == lpms_pkg::ST_DEEP);
  assign deep_powerdown_active = (s_q.fsm == lpms_pkg::ST_DPD);
  // analog power-down lines follow run config
  assign run_power_config = s_q.run_cfg;
  // enabled pending bit n is interrupt line n in every mode
  assign wake_irq = s_q.pend & s_q.en;

endmodule // lpms_sequencer

/* File: verification/low_power_mode_sequencer_tb_top.sv */
`timescale 1ns/100ps
`include "lpms_defines.svh"
module low_power_mode_sequencer_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, wait_instr = 0, irq = 0, ack, hold;
  logic clk_en, pwr_en, ds_req, in_ds, rc_ack, dpd, wpin = 0, wd = 0;
  logic [15:0] cfg;
  logic [39:0] pins = 40'h80_0000_0000, wirq;
  int slow = 0, failures = 0, compares = 0;
  always #25 pclk = ~pclk;
  lpms_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_for_interrupt_instr(wait_instr), .core_irq_pending(irq),
    .core_hold_ack(ack), .sleep_hold_req(hold), .core_clk_en(clk_en),
    .core_pwr_en(pwr_en), .deep_sleep_req(ds_req), .in_deep_sleep(in_ds),
    .internal_rc_osc_off_ack(rc_ack), .run_power_config(cfg),
    .port_pin(pins), .wake_irq(wirq), .deep_powerdown_wake_pin(wpin),
    .deep_powerdown_active(dpd));
  lpms_core_model i_core (.pclk(pclk), .presetn(presetn),
    .sleep_hold_req(hold), .core_clk_en(clk_en), .rc_off_req(cfg[0]),
    .withdraw(wd), .slow(slow), .core_hold_ack(ack),
    .internal_rc_osc_off_ack(rc_ack));
  task wrap_up;
    $display("checks %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (n == 20)
    begin
      failures++;
      wrap_up;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // w selects in_deep_sleep, else core clock
  task wt(input logic w, input logic v);
    int n;
    for (n = 0; n < 80 && (w ? in_ds : clk_en) !== v; n++)
      @(negedge pclk);
    if (n == 80)
    begin
      failures++;
      wrap_up;
    end
  endtask
  task pulse;
    @(posedge pclk);
    wait_instr <= 1;
    @(posedge pclk);
    wait_instr <= 0;
    @(negedge pclk);
  endtask
  initial
  begin
    #1000000;
    failures++;
    wrap_up;
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    chk("reset_clk", clk_en, 1);
    ap(0, 12'hFFC, 0);
    chk("unmapped_err", rerr, 1);
    chk("unmapped_data", rdat, 0);
    pulse;
    chk("sleep_clk", clk_en, 0);
    @(posedge pclk) irq <= 1;
    @(posedge pclk) irq <= 0;
    @(negedge pclk);
    chk("sleep_wake", clk_en, 1);
    ap(1, `LPMS_OFS_CLR_LO, 32'hFFFF_FFFF);
    ap(1, `LPMS_OFS_CLR_HI, 32'h0000_00FF);
    ap(1, `LPMS_OFS_POL_LO, 32'h0000_0020);
    ap(1, `LPMS_OFS_EN_LO, 32'h0000_0020);
    ap(1, `LPMS_OFS_EN_HI, 32'h0000_0080);
    @(posedge pclk) pins[5] <= 1;
    repeat (3) @(negedge pclk);
    chk("run_irq", wirq, 40'h00_0000_0020);
    chk("run_clk", clk_en, 1);
    ap(1, `LPMS_OFS_CLR_LO, 32'h0000_0020);
    ap(0, `LPMS_OFS_PEND_LO, 0);
    chk("pend_clr", rdat, 0);
    ap(1, `LPMS_OFS_SLPCFG, 32'h0000_00F0);
    ap(1, `LPMS_OFS_WAKCFG, 32'h0000_0006);
    ap(1, `LPMS_OFS_DSCTL, 32'h0000_0001);
    pulse;
    wt(1, 1);
    chk("deep_cfg", cfg, 16'h00F0);
    chk("deep_pwr", pwr_en, 0);
    chk("deep_req", ds_req, 1);
    @(posedge pclk) pins[5] <= 0;
    repeat (3) @(negedge pclk);
    chk("wrong_edge", in_ds, 1);
    @(posedge pclk) pins[5] <= 1;
    wt(0, 1);
    chk("wake_cfg", cfg, 16'h0006);
    ap(0, `LPMS_OFS_PEND_LO, 0);
    chk("pend_line", rdat, 32'h0000_0020);
    ap(1, `LPMS_OFS_CLR_LO, 32'h0000_0020);
    slow <= 3;
    ap(1, `LPMS_OFS_SLPCFG, 32'h0000_0001);
    pulse;
    chk("hold_req", hold, 1);
    @(posedge pclk) pins[39] <= 0;
    wt(1, 1);
    chk("rc_cfg", cfg, 16'h0001);
    wt(0, 1);
    chk("late_wake", wirq, 40'h80_0000_0000);
    ap(1, `LPMS_OFS_CLR_HI, 32'h0000_0080);
    slow <= 0;
    pins[39] <= 1;
    pulse;
    wt(1, 1);
    @(posedge pclk) wd <= 1;
    wt(0, 1);
    @(posedge pclk) wd <= 0;
    chk("withdraw_cfg", cfg, 16'h0006);
    slow <= 10;
    pulse;
    @(posedge pclk) irq <= 1;
    @(posedge pclk) irq <= 0;
    @(negedge pclk);
    chk("abandon_clk", clk_en, 1);
    chk("abandon_req", ds_req, 0);
    ap(1, `LPMS_OFS_DSCTL, 0);
    ap(1, `LPMS_OFS_GP0, 32'h5A5A_0FF0);
    ap(1, `LPMS_OFS_PCON, 32'h0000_0002);
    pulse;
    chk("dpd_on", dpd, 1);
    @(posedge pclk) wpin <= 1;
    wt(0, 1);
    @(posedge pclk) wpin <= 0;
    ap(0, `LPMS_OFS_GP0, 0);
    chk("retained", rdat, 32'h5A5A_0FF0);
    wrap_up;
  end
endmodule // low_power_mode_sequencer_tb_top

/* File: verification/lpms_core_model.sv */
`timescale 1ns/100ps
module lpms_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_hold_req,
  input wire logic core_clk_en,
  input wire logic rc_off_req,
  input wire logic withdraw,
  input wire logic [31:0] slow,
  output logic core_hold_ack,
  output logic internal_rc_osc_off_ack
);
  int cnt;
  logic [1:0] rc_q;
  assign internal_rc_osc_off_ack = rc_q[1];
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      core_hold_ack <= 1'b0;
      rc_q <= 2'b00;
    end
    else
    begin
      cnt <= sleep_hold_req ? cnt + 1 : 0;
      if (withdraw || core_clk_en)
        core_hold_ack <= 1'b0;
      else if (sleep_hold_req && cnt >= slow)
        core_hold_ack <= 1'b1;
      rc_q <= rc_off_req ? {rc_q[0], 1'b1} : 2'b00;
    end
  end
endmodule // lpms_core_model

/* File: verification/lpms_properties.sv */
`timescale 1ns/100ps
module lpms_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wait_for_interrupt_instr,
  input wire logic core_irq_pending,
  input wire logic core_hold_ack,
  input wire logic sleep_hold_req,
  input wire logic core_clk_en,
  input wire logic core_pwr_en,
  input wire logic deep_sleep_req,
  input wire logic in_deep_sleep,
  input wire logic internal_rc_osc_off_ack,
  input wire logic [15:0] run_power_config,
  input wire logic [39:0] wake_irq,
  input wire logic deep_powerdown_wake_pin,
  input wire logic deep_powerdown_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence dly_s;
    !in_deep_sleep ##1 in_deep_sleep;
  endsequence
  sequence rc_s;
    run_power_config[0] && !internal_rc_osc_off_ack;
  endsequence
  sleep_stop_a: assert property (
    core_clk_en && wait_for_interrupt_instr |=> !core_clk_en)
    else $error("core clock still on after wait instruction");
  sleep_exit_a: assert property (
    !core_clk_en && !sleep_hold_req && !deep_sleep_req
    && !deep_powerdown_active && core_irq_pending |=> core_clk_en)
    else $error("sleep not left on interrupt");
  run_power_a: assert property (core_clk_en |-> core_pwr_en)
    else $error("core clocked while unpowered");
  hold_wait_a: assert property (
    sleep_hold_req && !core_hold_ack |=> !deep_sleep_req)
    else $error("deep request without hold ack");
  abandon_a: assert property (
    sleep_hold_req && core_irq_pending |=> core_clk_en)
    else $error("hold not abandoned on interrupt");
  withdraw_a: assert property (
    deep_sleep_req && !core_hold_ack |=> !deep_sleep_req)
    else $error("deep request kept after withdraw");
  entry_hold_a: assert property (
    deep_sleep_req && !in_deep_sleep && core_hold_ack |=> deep_sleep_req)
    else $error("entry cut short");
  power_off_a: assert property (
    deep_sleep_req && core_pwr_en && core_hold_ack |=> !core_pwr_en)
    else $error("core not powered down");
  entry_delay_a: assert property (
    $fell(core_pwr_en) && deep_sleep_req && !run_power_config[0]
    && core_hold_ack |-> dly_s)
    else $error("entry delay wrong");
  rc_wait_a: assert property (
    ((deep_sleep_req && !core_pwr_en) and rc_s) |=> !in_deep_sleep)
    else $error("deep sleep before oscillator ack");
  deep_wake_a: assert property (
    in_deep_sleep && (|wake_irq) |=> core_clk_en)
    else $error("start logic did not wake");
  dpd_wake_a: assert property (
    deep_powerdown_active && deep_powerdown_wake_pin |=> core_clk_en)
    else $error("wake pin ignored");
endmodule // lpms_props
bind lpms_sequencer lpms_props i_props (.pclk, .presetn,
  .wait_for_interrupt_instr, .core_irq_pending, .core_hold_ack,
  .sleep_hold_req, .core_clk_en, .core_pwr_en, .deep_sleep_req,
  .in_deep_sleep, .internal_rc_osc_off_ack, .run_power_config,
  .wake_irq, .deep_powerdown_wake_pin, .deep_powerdown_active);
